// file: hw/lpso_pkg.sv
// Purpose: shared constants for the laser program status outputs block
// Assumes: 125 MHz core clock, AXI4-Lite register access with 32-bit data
// Notes: offsets are byte addresses, one aligned word per register
package lpso_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register fields
  localparam int CTRL_ADDR_LSB = 0;
  localparam int UNIT_ADDR_W = 4;
  localparam logic [UNIT_ADDR_W-1:0] UNIT_ADDR_RST = 4'h0;

  // gate channel code
  localparam int GATE_W = 4;
  localparam logic [GATE_W-1:0] GATE_CLOSED = 4'h0;
  localparam logic [GATE_W-1:0] GATE_MAX = 4'h3;

  // status register bit positions
  localparam int ST_RUNNING = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ABNORMAL = 2;
  localparam int ST_SYNC = 3;
  localparam int ST_WARNING = 4;
  localparam int ST_COOL_WARN = 5;
  localparam int ST_COOL_ALARM = 6;
  localparam int ST_PULSED = 7;
  localparam int ST_GATE_LSB = 8;
  localparam int ST_UNIT_LSB = 12;

  // interrupt event bit positions
  localparam int IRQ_W = 5;
  localparam int EV_DONE = 0;
  localparam int EV_ABNORMAL = 1;
  localparam int EV_COOL_ALARM = 2;
  localparam int EV_WARNING = 3;
  localparam int EV_ALARM_CLEAR = 4;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

  // alarm-clear minimum high time
  localparam int CLK_HZ = 125_000_000;
  localparam int CLR_HOLD_MS = 1;
  localparam int CLR_HOLD_CYC = (CLK_HZ / 1000) * CLR_HOLD_MS;

  // number of synchronised pin inputs
  localparam int PIN_W = 3 + GATE_W;

endpackage

// file: hw/lpso_sync2.sv
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: each bit is an independent slow level
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module lpso_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic CORE_CLK, // core clock
  input wire logic SRST, // synchronous reset, active high
  input wire logic [WIDTH-1:0] PIN_IN, // asynchronous pin levels
  output logic [WIDTH-1:0] PIN_SYNC // synchronised levels
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      meta_reg <= '0;
      PIN_SYNC <= '0;
    end else begin
      meta_reg <= PIN_IN;
      PIN_SYNC <= meta_reg;
    end
  end
endmodule // lpso_sync2
`default_nettype wire

// file: hw/lpso_top.sv
// Purpose: status outputs of the hardwired control connector, with AXI4-Lite registers
// Assumes: program engine and cooling monitor on CORE_CLK; connector inputs asynchronous
// Notes: all connector outputs are registered; irq status clears on read
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - program done rises when a program finishes, falls once start enable drops
// - abnormal end rises on abnormal termination, cleared by the alarm-clear input
// - sync output follows the program only while programming mode is active
// - warning output high exactly while any warning condition stands
// - gate indicator is a 4-bit code: zero closed, one to three open channel
// - coolant warning output follows the water temperature warning; emission stays allowed
// - coolant alarm output follows the temperature alarm and inhibits emission meanwhile
// - pulsed-mode indicator shows quasi-continuous mode on units that support it
// - unit address is output as a 4-bit code, zero or one for lasers
// - alarm clear acts once the pin has been held high 1 ms, not on its rising edge
// - gate channel opened follows the 4-bit select for codes up to three and holds on larger codes; zero closes all channels
// - program running output is high for the whole program execution
module lpso_top
  import lpso_pkg::*;
#(
  parameter int CLR_HOLD = lpso_pkg::CLR_HOLD_CYC,
  parameter bit QCW_SUPPORTED = 1'b1
) (
  input wire logic CORE_CLK, // core clock, 125 MHz
  input wire logic SRST, // synchronous reset, active high
  input wire logic [lpso_pkg::ADDR_W-1:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [lpso_pkg::DATA_W-1:0] S_AXI_WDATA, // write data
  input wire logic [lpso_pkg::STRB_W-1:0] S_AXI_WSTRB, // write byte strobes
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [lpso_pkg::ADDR_W-1:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [lpso_pkg::DATA_W-1:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY, // read data ready
  input wire logic PROGRAM_START_ENABLE, // connector pin, asynchronous
  input wire logic ALARM_CLEAR_IN, // connector pin, asynchronous
  input wire logic [lpso_pkg::GATE_W-1:0] GATE_CHANNEL_SELECT, // connector pins, asynchronous
  input wire logic QUASI_CONTINUOUS_OPERATION, // connector pin, asynchronous
  input wire logic PROG_MODE, // programming mode active
  input wire logic PROG_EXECUTING, // program engine busy
  input wire logic PROG_FINISHED, // pulse, program ended normally
  input wire logic PROG_ABORTED, // pulse, program ended abnormally
  input wire logic PROG_SYNC_REQ, // sync level dictated by the program
  input wire logic WARNING_COND, // any warning present
  input wire logic COOLANT_WARN_COND, // water temperature warning
  input wire logic COOLANT_ALARM_COND, // water temperature alarm
  output logic PROGRAM_RUNNING_OUT, // program running
  output logic PROGRAM_DONE_OUT, // program ended normally
  output logic ABNORMAL_END_OUT, // program ended abnormally
  output logic PROGRAM_SYNC_OUT, // program sync output
  output logic WARNING_OUT, // warning present
  output logic [lpso_pkg::GATE_W-1:0] GATE_CHANNEL_INDICATOR, // open gate channel code
  output logic [lpso_pkg::GATE_W-1:0] GATE_CHANNEL_OPEN, // gate channel to open
  output logic COOLANT_WARNING_OUT, // coolant warning
  output logic COOLANT_ALARM_OUT, // coolant alarm
  output logic EMISSION_INHIBIT, // emission forbidden
  output logic PULSED_MODE_INDICATOR, // quasi-continuous mode active
  output logic [lpso_pkg::UNIT_ADDR_W-1:0] UNIT_ADDRESS_OUT, // unit address code
  output logic PROG_START_PULSE, // pulse, program start request
  output logic ALARM_CLEAR_PULSE, // pulse, qualified alarm clear
  output logic IRQ // interrupt, active high level
);
  import lpso_pkg::*;

  localparam int CNT_W = $clog2(CLR_HOLD + 1);
  localparam logic [CNT_W-1:0] CLR_LAST = CNT_W'(CLR_HOLD - 1);
  localparam logic [CNT_W-1:0] CLR_FULL = CNT_W'(CLR_HOLD);

  // register match against an aligned word offset
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    addr_is = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // pin synchronisation
  wire logic [PIN_W-1:0] pin_raw;
  wire logic [PIN_W-1:0] pin_sync;
  wire logic start_en_s;
  wire logic clear_s;
  wire logic qcw_s;
  wire logic [GATE_W-1:0] gate_sel_s;

  assign pin_raw = {GATE_CHANNEL_SELECT, QUASI_CONTINUOUS_OPERATION, ALARM_CLEAR_IN, PROGRAM_START_ENABLE};
  assign start_en_s = pin_sync[0];
  assign clear_s = pin_sync[1];
  assign qcw_s = pin_sync[2];
  assign gate_sel_s = pin_sync[PIN_W-1:3];

  lpso_sync2 #(
    .WIDTH(PIN_W)
  ) u_sync (
    .CORE_CLK(CORE_CLK),
    .SRST(SRST),
    .PIN_IN(pin_raw),
    .PIN_SYNC(pin_sync)
  );

  // start edge detect and alarm-clear qualification
  logic start_en_d_reg;
  logic [CNT_W-1:0] clr_cnt_reg;
  logic [CNT_W-1:0] clr_cnt_next;
  wire logic start_edge;
  wire logic clr_fire;

  assign start_edge = start_en_s & ~start_en_d_reg & PROG_MODE;
  assign clr_fire = clear_s & (clr_cnt_reg == CLR_LAST);
  assign clr_cnt_next = !clear_s ? '0 : (clr_cnt_reg == CLR_FULL) ? clr_cnt_reg : clr_cnt_reg + 1'b1;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      start_en_d_reg <= 1'b0;
      clr_cnt_reg <= '0;
    end else begin
      start_en_d_reg <= start_en_s;
      clr_cnt_reg <= clr_cnt_next;
    end
  end

  // status flags; set wins over clear
  logic done_reg;
  logic abnormal_reg;
  logic [GATE_W-1:0] gate_reg;
  logic [UNIT_ADDR_W-1:0] unit_addr_reg;
  wire logic done_next;
  wire logic abnormal_next;
  wire logic gate_valid;
  wire logic [GATE_W-1:0] gate_next;
  wire logic pulsed_next;
  wire logic sync_next;

  assign done_next = PROG_FINISHED | (done_reg & start_en_s);
  assign abnormal_next = PROG_ABORTED | (abnormal_reg & ~clr_fire);
  assign gate_valid = (gate_sel_s <= GATE_MAX);
  assign gate_next = gate_valid ? gate_sel_s : gate_reg;
  assign pulsed_next = QCW_SUPPORTED & qcw_s;
  assign sync_next = PROG_MODE & PROG_SYNC_REQ;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      done_reg <= 1'b0;
      abnormal_reg <= 1'b0;
      gate_reg <= GATE_CLOSED;
    end else begin
      done_reg <= done_next;
      abnormal_reg <= abnormal_next;
      gate_reg <= gate_next;
    end
  end

  // registered connector outputs
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      PROGRAM_RUNNING_OUT <= 1'b0;
      PROGRAM_DONE_OUT <= 1'b0;
      ABNORMAL_END_OUT <= 1'b0;
      PROGRAM_SYNC_OUT <= 1'b0;
      WARNING_OUT <= 1'b0;
      GATE_CHANNEL_INDICATOR <= GATE_CLOSED;
      GATE_CHANNEL_OPEN <= GATE_CLOSED;
      COOLANT_WARNING_OUT <= 1'b0;
      COOLANT_ALARM_OUT <= 1'b0;
      EMISSION_INHIBIT <= 1'b0;
      PULSED_MODE_INDICATOR <= 1'b0;
      UNIT_ADDRESS_OUT <= UNIT_ADDR_RST;
      PROG_START_PULSE <= 1'b0;
      ALARM_CLEAR_PULSE <= 1'b0;
    end else begin
      PROGRAM_RUNNING_OUT <= PROG_EXECUTING;
      PROGRAM_DONE_OUT <= done_next;
      ABNORMAL_END_OUT <= abnormal_next;
      PROGRAM_SYNC_OUT <= sync_next;
      WARNING_OUT <= WARNING_COND;
      GATE_CHANNEL_INDICATOR <= gate_next;
      GATE_CHANNEL_OPEN <= gate_next;
      COOLANT_WARNING_OUT <= COOLANT_WARN_COND;
      COOLANT_ALARM_OUT <= COOLANT_ALARM_COND;
      EMISSION_INHIBIT <= COOLANT_ALARM_COND;
      PULSED_MODE_INDICATOR <= pulsed_next;
      UNIT_ADDRESS_OUT <= unit_addr_reg;
      PROG_START_PULSE <= start_edge;
      ALARM_CLEAR_PULSE <= clr_fire;
    end
  end

  // interrupt events
  logic cool_alarm_d_reg;
  logic warning_d_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_status_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  wire logic [IRQ_W-1:0] events;
  wire logic status_rd;

  assign events[EV_DONE] = PROG_FINISHED;
  assign events[EV_ABNORMAL] = PROG_ABORTED;
  assign events[EV_COOL_ALARM] = COOLANT_ALARM_COND & ~cool_alarm_d_reg;
  assign events[EV_WARNING] = WARNING_COND & ~warning_d_reg;
  assign events[EV_ALARM_CLEAR] = clr_fire;
  assign irq_status_next = (status_rd ? '0 : irq_status_reg) | events;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      cool_alarm_d_reg <= 1'b0;
      warning_d_reg <= 1'b0;
      irq_status_reg <= IRQ_RST;
      IRQ <= 1'b0;
    end else begin
      cool_alarm_d_reg <= COOLANT_ALARM_COND;
      warning_d_reg <= WARNING_COND;
      irq_status_reg <= irq_status_next;
      IRQ <= |(irq_status_next & irq_mask_reg);
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  logic aw_have_reg;
  logic w_have_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [STRB_W-1:0] w_strb_reg;
  wire logic aw_take;
  wire logic w_take;
  wire logic aw_full;
  wire logic w_full;
  wire logic [ADDR_W-1:0] wr_addr;
  wire logic [DATA_W-1:0] wr_data;
  wire logic [STRB_W-1:0] wr_strb;
  wire logic wr_fire;
  wire logic wr_ctrl;
  wire logic wr_mask;
  wire logic wr_known;

  assign aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_take = S_AXI_WVALID & S_AXI_WREADY;
  assign aw_full = aw_have_reg | aw_take;
  assign w_full = w_have_reg | w_take;
  assign wr_addr = aw_have_reg ? aw_addr_reg : S_AXI_AWADDR;
  assign wr_data = w_have_reg ? w_data_reg : S_AXI_WDATA;
  assign wr_strb = w_have_reg ? w_strb_reg : S_AXI_WSTRB;
  assign wr_fire = aw_full & w_full & ~S_AXI_BVALID;
  assign wr_ctrl = wr_fire & addr_is(wr_addr, OFS_CTRL) & wr_strb[0];
  assign wr_mask = wr_fire & addr_is(wr_addr, OFS_IRQ_MASK) & wr_strb[0];
  assign wr_known = addr_is(wr_addr, OFS_CTRL) | addr_is(wr_addr, OFS_STATUS)
                  | addr_is(wr_addr, OFS_IRQ_STATUS) | addr_is(wr_addr, OFS_IRQ_MASK);

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      aw_have_reg <= aw_full & ~wr_fire;
      w_have_reg <= w_full & ~wr_fire;
      if (aw_take) begin
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      // ready only while nothing of that channel is held or answered
      S_AXI_AWREADY <= ~(aw_full & ~wr_fire) & ~aw_take & ~(S_AXI_BVALID & ~S_AXI_BREADY) & ~wr_fire;
      S_AXI_WREADY <= ~(w_full & ~wr_fire) & ~w_take & ~(S_AXI_BVALID & ~S_AXI_BREADY) & ~wr_fire;
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // software registers
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      unit_addr_reg <= UNIT_ADDR_RST;
      irq_mask_reg <= IRQ_RST;
    end else begin
      if (wr_ctrl) begin
        unit_addr_reg <= wr_data[CTRL_ADDR_LSB +: UNIT_ADDR_W];
      end
      if (wr_mask) begin
        irq_mask_reg <= wr_data[IRQ_W-1:0];
      end
    end
  end

  // AXI4-Lite read path
  wire logic rd_fire;
  wire logic [DATA_W-1:0] status_word;
  wire logic [DATA_W-1:0] rd_word;
  wire logic rd_known;

  assign rd_fire = S_AXI_ARVALID & S_AXI_ARREADY;
  assign status_rd = rd_fire & addr_is(S_AXI_ARADDR, OFS_IRQ_STATUS);
  assign status_word = {16'h0000, UNIT_ADDRESS_OUT, GATE_CHANNEL_INDICATOR, PULSED_MODE_INDICATOR,
                        COOLANT_ALARM_OUT, COOLANT_WARNING_OUT, WARNING_OUT, PROGRAM_SYNC_OUT,
                        ABNORMAL_END_OUT, PROGRAM_DONE_OUT, PROGRAM_RUNNING_OUT};
  assign rd_known = addr_is(S_AXI_ARADDR, OFS_CTRL) | addr_is(S_AXI_ARADDR, OFS_STATUS)
                  | addr_is(S_AXI_ARADDR, OFS_IRQ_STATUS) | addr_is(S_AXI_ARADDR, OFS_IRQ_MASK);
  assign rd_word = addr_is(S_AXI_ARADDR, OFS_CTRL) ? {{(DATA_W-UNIT_ADDR_W){1'b0}}, unit_addr_reg}
                 : addr_is(S_AXI_ARADDR, OFS_STATUS) ? status_word
                 : addr_is(S_AXI_ARADDR, OFS_IRQ_STATUS) ? {{(DATA_W-IRQ_W){1'b0}}, irq_status_reg}
                 : addr_is(S_AXI_ARADDR, OFS_IRQ_MASK) ? {{(DATA_W-IRQ_W){1'b0}}, irq_mask_reg}
                 : '0;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ~rd_fire & ~(S_AXI_RVALID & ~S_AXI_RREADY);
      if (rd_fire) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule // lpso_top
`default_nettype wire

// file: sim/lpso_chk_sva.sv
// Purpose: concurrent checks on the status outputs of lpso_top
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every lpso_top instance by port name
`timescale 1ns/1ps
`default_nettype none
module lpso_chk
  import lpso_pkg::*;
(
  input wire logic CORE_CLK, // core clock
  input wire logic SRST, // synchronous reset
  input wire logic PROGRAM_START_ENABLE, // start enable pin
  input wire logic ALARM_CLEAR_IN, // alarm clear pin
  input wire logic PROG_MODE, // programming mode
  input wire logic PROG_EXECUTING, // engine busy
  input wire logic PROG_FINISHED, // normal end pulse
  input wire logic PROG_ABORTED, // abnormal end pulse
  input wire logic PROG_SYNC_REQ, // sync level request
  input wire logic WARNING_COND, // warning level
  input wire logic COOLANT_WARN_COND, // coolant warning level
  input wire logic COOLANT_ALARM_COND, // coolant alarm level
  input wire logic PROGRAM_RUNNING_OUT, // running output
  input wire logic PROGRAM_DONE_OUT, // done output
  input wire logic ABNORMAL_END_OUT, // abnormal end output
  input wire logic PROGRAM_SYNC_OUT, // sync output
  input wire logic WARNING_OUT, // warning output
  input wire logic [lpso_pkg::GATE_W-1:0] GATE_CHANNEL_INDICATOR, // gate code
  input wire logic [lpso_pkg::GATE_W-1:0] GATE_CHANNEL_OPEN, // gate opened
  input wire logic COOLANT_WARNING_OUT, // coolant warning output
  input wire logic COOLANT_ALARM_OUT, // coolant alarm output
  input wire logic EMISSION_INHIBIT, // emission forbidden
  input wire logic ALARM_CLEAR_PULSE // qualified clear pulse
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SRST);
  sequence s_fin;
    PROG_FINISHED ##1 PROGRAM_DONE_OUT;
  endsequence
  sequence s_abort;
    PROG_ABORTED ##1 ABNORMAL_END_OUT;
  endsequence
  property p_done_set; PROG_FINISHED |-> s_fin; endproperty
  a_done_set: assert property (p_done_set) else $error("done not raised");
  property p_done_clr; $fell(PROGRAM_DONE_OUT) |-> !$past(PROGRAM_START_ENABLE, 3); endproperty
  a_done_clr: assert property (p_done_clr) else $error("done dropped with start high");
  property p_abn_set; PROG_ABORTED |-> s_abort; endproperty
  a_abn_set: assert property (p_abn_set) else $error("abnormal end not raised");
  property p_abn_clr; $fell(ABNORMAL_END_OUT) |-> ALARM_CLEAR_PULSE; endproperty
  a_abn_clr: assert property (p_abn_clr) else $error("abnormal end dropped unasked");
  property p_clr_qual; ALARM_CLEAR_PULSE |-> $past(ALARM_CLEAR_IN, 3) && $past(ALARM_CLEAR_IN, 8); endproperty
  a_clr_qual: assert property (p_clr_qual) else $error("clear without held pin");
  property p_sync; !$past(SRST) |-> PROGRAM_SYNC_OUT == ($past(PROG_MODE) && $past(PROG_SYNC_REQ)); endproperty
  a_sync: assert property (p_sync) else $error("sync output wrong");
  property p_warn; !$past(SRST) |-> WARNING_OUT == $past(WARNING_COND); endproperty
  a_warn: assert property (p_warn) else $error("warning output wrong");
  property p_cool; !$past(SRST) |-> COOLANT_WARNING_OUT == $past(COOLANT_WARN_COND); endproperty
  a_cool: assert property (p_cool) else $error("coolant warning wrong");
  property p_alarm;
    !$past(SRST) |-> COOLANT_ALARM_OUT == $past(COOLANT_ALARM_COND) && EMISSION_INHIBIT == COOLANT_ALARM_OUT;
  endproperty
  a_alarm: assert property (p_alarm) else $error("coolant alarm or inhibit wrong");
  property p_run; !$past(SRST) |-> PROGRAM_RUNNING_OUT == $past(PROG_EXECUTING); endproperty
  a_run: assert property (p_run) else $error("running output wrong");
  property p_gate; GATE_CHANNEL_INDICATOR == GATE_CHANNEL_OPEN && GATE_CHANNEL_INDICATOR <= GATE_MAX; endproperty
  a_gate: assert property (p_gate) else $error("gate code wrong");
endmodule // lpso_chk
bind lpso_top lpso_chk u_chk (.*);
`default_nettype wire

// file: sim/lpso_ctrl_model.sv
// Purpose: machine controller driving the start and clear pins
// Assumes: pins change by non-blocking assignment after a clock edge
// Notes: clear hold time is chosen by the caller
`timescale 1ns/1ps
`default_nettype none
module lpso_ctrl_model (
  input wire logic core_clk, // core clock
  input wire logic running, // program running status
  output logic start_en, // start enable pin
  output logic clr_pin // alarm clear pin
);
  initial begin
    start_en = 1'b0;
    clr_pin = 1'b0;
  end
  task automatic start();
    @(posedge core_clk);
    start_en <= 1'b1;
  endtask
  // keep start high until the run is over
  task automatic finish(output bit ok);
    int n;
    n = 0;
    while (running && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    ok = !running;
    @(posedge core_clk);
    start_en <= 1'b0;
  endtask
  task automatic clear_alarm(input int hold);
    @(posedge core_clk);
    clr_pin <= 1'b1;
    repeat (hold) @(posedge core_clk);
    clr_pin <= 1'b0;
  endtask
endmodule // lpso_ctrl_model
`default_nettype wire

// file: sim/testbench.sv
// Purpose: self-checking bench for lpso_top
// Assumes: 125 MHz clock, short alarm-clear hold in simulation
// Notes: outputs are read just after an edge, before it updates them
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected t=%0t got %0h want %0h", $time, a, e); end end
module testbench;
  import lpso_pkg::*;
  localparam int HOLD = 8;
  logic clk = 0, srst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, d;
  logic [STRB_W-1:0] wstrb = 4'hF;
  logic awr, wrr, bv, arr, rv, start_en, clr_pin, run, done, abn, sync_o, warn_o;
  logic cw_o, ca_o, inh, pulsed, spulse, cpulse, irq;
  logic quasi_continuous_operation = 0, mode = 0, exe = 0, fin = 0, abt = 0, sreq = 0, warn = 0, cwarn = 0, calarm = 0;
  logic [1:0] bresp, rresp, r;
  logic [GATE_W-1:0] gsel = '0, gind, gopen;
  logic [UNIT_ADDR_W-1:0] unit;
  bit ok;
  int err_total = 0, comparisons = 0;
  lpso_top #(.CLR_HOLD(HOLD), .QCW_SUPPORTED(1'b1)) uut (
    .CORE_CLK(clk), .SRST(srst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .PROGRAM_START_ENABLE(start_en),
    .ALARM_CLEAR_IN(clr_pin), .GATE_CHANNEL_SELECT(gsel), .QUASI_CONTINUOUS_OPERATION(quasi_continuous_operation),
    .PROG_MODE(mode), .PROG_EXECUTING(exe), .PROG_FINISHED(fin), .PROG_ABORTED(abt),
    .PROG_SYNC_REQ(sreq), .WARNING_COND(warn), .COOLANT_WARN_COND(cwarn),
    .COOLANT_ALARM_COND(calarm), .PROGRAM_RUNNING_OUT(run), .PROGRAM_DONE_OUT(done),
    .ABNORMAL_END_OUT(abn), .PROGRAM_SYNC_OUT(sync_o), .WARNING_OUT(warn_o),
    .GATE_CHANNEL_INDICATOR(gind), .GATE_CHANNEL_OPEN(gopen), .COOLANT_WARNING_OUT(cw_o),
    .COOLANT_ALARM_OUT(ca_o), .EMISSION_INHIBIT(inh), .PULSED_MODE_INDICATOR(pulsed),
    .UNIT_ADDRESS_OUT(unit), .PROG_START_PULSE(spulse), .ALARM_CLEAR_PULSE(cpulse), .IRQ(irq));
  lpso_ctrl_model ctl (.core_clk(clk), .running(run), .start_en(start_en), .clr_pin(clr_pin));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic timeout();
    err_total++;
    $display("unexpected t=%0t wait limit reached", $time);
    conclude();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wrr) wv <= 1'b0;
    end while (!bv && n < 50);
    if (!bv) timeout();
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (!rv && n < 50);
    if (!rv) timeout();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_reset();
    warn <= 1'b1;
    calarm <= 1'b1;
    tick(3);
    srst <= 1'b1;
    tick(3);
    `CHK({warn_o, ca_o, inh, run, done, abn, irq}, 7'h00)
    `CHK({unit, gind}, 8'h00)
    srst <= 1'b0;
    warn <= 1'b0;
    calarm <= 1'b0;
    tick(3);
    $display("test reset finished");
  endtask
  task automatic t_unit();
    for (int i = 1; i >= 0; i--) begin
      wr(OFS_CTRL, i);
      `CHK(r, RESP_OKAY)
      tick(2);
      `CHK(unit, i[3:0])
      rd(OFS_STATUS);
      `CHK(d[ST_UNIT_LSB +: 4], i[3:0])
    end
    rd(8'h40);
    `CHK(r, RESP_SLVERR)
    wr(8'h40, 32'h0000_0001);
    `CHK(r, RESP_SLVERR)
    $display("test unit finished");
  endtask
  task automatic t_levels();
    mode <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      {warn, cwarn, calarm, sreq} <= i[3:0];
      tick(2);
      `CHK(warn_o, i[3])
      `CHK(cw_o, i[2])
      `CHK({ca_o, inh}, {2{i[1]}})
      `CHK(sync_o, i[0])
    end
    mode <= 1'b0;
    tick(2);
    `CHK(sync_o, 1'b0)
    {warn, cwarn, calarm, sreq} <= 4'h0;
    tick(2);
    $display("test levels finished");
  endtask
  task automatic t_gate();
    for (int i = 0; i < 5; i++) begin
      gsel <= (i == 4) ? 4'hA : i[3:0];
      tick(5);
      `CHK(gind, (i == 4) ? 4'h3 : i[3:0])
      `CHK(gopen, (i == 4) ? 4'h3 : i[3:0])
    end
    quasi_continuous_operation <= 1'b1;
    tick(5);
    `CHK(pulsed, 1'b1)
    quasi_continuous_operation <= 1'b0;
    tick(5);
    `CHK(pulsed, 1'b0)
    $display("test gate finished");
  endtask
  task automatic t_program();
    int n;
    n = 0;
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    mode <= 1'b1;
    ctl.start();
    while (!spulse && n < 10) begin
      @(posedge clk);
      n++;
    end
    `CHK(spulse, 1'b1)
    exe <= 1'b1;
    tick(2);
    `CHK(run, 1'b1)
    fin <= 1'b1;
    exe <= 1'b0;
    tick(1);
    fin <= 1'b0;
    tick(2);
    `CHK({done, irq, run}, 3'b110)
    ctl.finish(ok);
    `CHK(ok, 1'b1)
    tick(6);
    `CHK(done, 1'b0)
    rd(OFS_IRQ_STATUS);
    `CHK(d[IRQ_W-1:0], IRQ_W'((1 << EV_DONE) | (1 << EV_COOL_ALARM) | (1 << EV_WARNING)))
    rd(OFS_IRQ_STATUS);
    `CHK(d[IRQ_W-1:0], IRQ_RST)
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    fin <= 1'b1;
    tick(1);
    fin <= 1'b0;
    tick(3);
    `CHK(irq, 1'b0)
    $display("test program finished");
  endtask
  task automatic t_abnormal();
    abt <= 1'b1;
    tick(1);
    abt <= 1'b0;
    tick(2);
    `CHK(abn, 1'b1)
    ctl.clear_alarm(HOLD - 3);
    tick(8);
    `CHK(abn, 1'b1)
    ctl.clear_alarm(HOLD + 6);
    tick(3);
    `CHK(abn, 1'b0)
    rd(OFS_IRQ_STATUS);
    `CHK(d[IRQ_W-1:0], IRQ_W'((1 << EV_DONE) | (1 << EV_ABNORMAL) | (1 << EV_ALARM_CLEAR)))
    $display("test abnormal finished");
  endtask
  initial begin
    tick(20);
    srst <= 1'b0;
    tick(3);
    t_reset();
    t_unit();
    t_levels();
    t_gate();
    t_program();
    t_abnormal();
    conclude();
  end
endmodule // testbench
`default_nettype wire
